// ==== dv/tarc_properties.sv ====
// Port assertions for the retry controller.
// Assumes a bind onto tarc_retry_ctrl.
`timescale 1ns/100ps
`default_nettype none
module tarc_properties #(parameter int TICK_CYC = 4) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [3:0] retry_count_limit,
  input wire logic [7:0] retry_interval,
  input wire logic [7:0] tripCause,
  input wire logic alarmAck,
  input wire logic tripReset,
  input wire logic faultAlarm,
  input wire logic tripped,
  input wire logic [3:0] retryCount
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_pulse; tripReset |-> !faultAlarm ##1 !tripReset; endproperty
  a_pulse: assert property (p_pulse) else $error("bad restart");
  property p_limit; tripReset |-> retryCount <= retry_count_limit; endproperty
  a_limit: assert property (p_limit) else $error("over limit");
  property p_hold; (!alarmAck)[*4] ##0 faultAlarm |=> faultAlarm; endproperty
  a_hold: assert property (p_hold) else $error("alarm lost");
  property p_wait; retry_interval != 0 && $rose(tripped) |-> (!tripReset)[*4];
  endproperty
  a_wait: assert property (p_wait) else $error("early restart");
  property p_other; $rose(tripCause[7]) |-> ##[1:4] faultAlarm; endproperty
  a_other: assert property (p_other) else $error("no alarm");
  cover property (tripReset);
  cover property ($rose(faultAlarm) && retryCount != 0);
  cover property ($rose(tripCause[7]));
endmodule : tarc_properties
`default_nettype wire

// ==== dv/tarc_prot_model.sv ====
// Protection functions holding fault levels.
// Assumes faults are fired on clk_sys.
`timescale 1ns/100ps
`default_nettype none
module tarc_prot_model (
  input wire logic clk_sys,
  input wire logic [7:0] fire,
  input wire logic clear,
  input wire logic tripReset,
  output logic [7:0] tripCause
);
  initial tripCause = 8'h00;
  // A restart removes the fault behind the trip
  always @(posedge clk_sys)
    tripCause <= (clear || tripReset) ? 8'h00 : tripCause | fire;
endmodule : tarc_prot_model
`default_nettype wire

// ==== dv/tarc_retry_ctrl_tb_top.sv ====
// Bench for the retry controller.
// Assumes TICK_CYC is cut to 4 cycles.
`timescale 1ns/100ps
`default_nettype none
module tarc_retry_ctrl_tb_top;
  logic clk_sys = 0, rst_n = 0, alarmAck = 0, clear = 1;
  logic [3:0] lim = 4'h0;
  logic [7:0] ivl = 8'h01, fire = 8'h00, tripCause, cause;
  logic tripReset, faultAlarm, tripped;
  logic [3:0] retryCount;
  integer seed = 60;
  int failures = 0, checks = 0, cnt = 0, s, k;
  initial forever #20 clk_sys = ~clk_sys;
  tarc_prot_model u_prot (.clk_sys, .fire, .clear, .tripReset, .tripCause);
  tarc_retry_ctrl #(.TICK_CYC(4)) dut (.clk_sys, .rst_n,
    .retry_count_limit(lim), .retry_interval(ivl), .tripCause, .alarmAck,
    .tripReset, .faultAlarm, .tripped, .retryCount);
  task cmp(input logic [3:0] e, input logic [3:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %0t %h %h", $time, e, g);
    end
  endtask : cmp
  task report_and_stop;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  task trip(input logic [7:0] c, input logic [7:0] late);
    int n;
    logic al;
    n = 0;
    @(posedge clk_sys) fire <= c;
    @(posedge clk_sys) fire <= 8'h00;
    if (late != 8'h00) begin
      // Foreign fault while the retry wait still runs
      repeat (6) @(posedge clk_sys);
      fire <= late;
      @(posedge clk_sys) fire <= 8'h00;
    end
    while (!(tripReset === 1'b1 || faultAlarm === 1'b1) && n < 300) begin
      @(posedge clk_sys);
      #1 n++;
    end
    al = c[7] || late != 8'h00 || cnt >= lim;
    if (late != 8'h00) cnt++;
    cmp({3'h0, al}, {3'h0, faultAlarm});
    cmp({3'h0, !al}, {3'h0, tripReset});
    cmp({3'h0, al}, {3'h0, tripped});
    if (!al) begin
      cnt++;
      cmp(4'(cnt), retryCount);
      cmp(4'h1, {3'h0, n >= ivl * 4});
    end else begin
      cmp(4'(cnt), retryCount);
      @(posedge clk_sys);
      alarmAck <= 1;
      clear <= 1;
      repeat (6) @(posedge clk_sys);
      alarmAck <= 0;
      clear <= 0;
      cnt = 0;
      #1 cmp(4'h0, retryCount);
      cmp(4'h0, {3'h0, tripped});
    end
    repeat (2) @(posedge clk_sys);
  endtask : trip
  initial begin
    repeat (8) @(posedge clk_sys);
    rst_n <= 1;
    clear <= 0;
    for (s = 0; s < 8; s++) begin
      @(posedge clk_sys);
      lim <= 4'({$random(seed)} % 4);
      ivl <= 8'({$random(seed)} % 3 + 1);
      @(posedge clk_sys);
      for (k = 0; k <= lim; k++) begin
        cause = 8'h01 << ((s + k) % 7);
        if (k == 0 && s == 3) cause = 8'h80;
        if (k == 0 && s == 5) cause = 8'h81;
        trip(cause, 8'h00);
      end
    end
    // Zero interval, then a foreign fault during a pending retry
    lim <= 4'hf;
    ivl <= 8'h00;
    @(posedge clk_sys);
    trip(8'h40, 8'h00);
    ivl <= 8'h03;
    trip(8'h02, 8'h80);
    report_and_stop;
  end
  // Runs stay under 800 cycles; the margin is wide
  initial begin
    repeat (9000) @(posedge clk_sys);
    failures++;
    report_and_stop;
  end
endmodule : tarc_retry_ctrl_tb_top
bind tarc_retry_ctrl tarc_properties #(.TICK_CYC(TICK_CYC)) u_props (
  .clk_sys, .rst_n, .retry_count_limit, .retry_interval, .tripCause,
  .alarmAck, .tripReset, .faultAlarm, .tripped, .retryCount);
`default_nettype wire

// ==== verilog/tarc_defs.svh ====
// Constants for the trip auto-retry controller.
// Assumes inclusion by the package and the design modules.
// Notes on behaviour
// - With retry on, an eligible trip is cleared and restarted, alarm stays off.
// - When trips exceed the retry count, raise the alarm and stop retrying.
// - Eligible causes: overcurrent, overvoltage, sink, drive, motor heat, overloads.
// - Wait the programmed retry interval before each automatic reset attempt.
`ifndef TARC_DEFS_SVH
`define TARC_DEFS_SVH

// ****************************************************************
// Widths and encodings
// ****************************************************************
`define TARC_CAUSE_W 8
`define TARC_COUNT_W 4
`define TARC_IVL_W 8
// Eligible trip causes, one bit each on the cause vector
`define TARC_ELIGIBLE_MASK 8'h7f
// Interval unit: 100 ms per step
`define TARC_TICK_NS 100000000
`define TARC_CLK_NS 40
`define TARC_TICK_CYC (`TARC_TICK_NS / `TARC_CLK_NS)
`define TARC_RESET_PULSE_CYC 1

`endif

// ==== verilog/tarc_interval_timer.sv ====
// Interval timer counting 100 ms steps for retry spacing.
// Assumes clk_sys at 25 MHz, synchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "tarc_defs.svh"
module tarc_interval_timer #(
  parameter int TICK_CYC = `TARC_TICK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control side
  tarc_timer_if.timer tmr
);
  logic [31:0] tickCount;
  logic [`TARC_IVL_W-1:0] stepsLeft;
  logic running;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || tmr.start) begin
      tickCount <= 32'h0;
    end else if (running) begin
      tickCount <= (tickCount == 32'(TICK_CYC - 1)) ? 32'h0 : tickCount + 32'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      running <= 1'b0;
      stepsLeft <= '0;
      tmr.done <= 1'b0;
    end else begin
      tmr.done <= 1'b0;
      if (tmr.start) begin
        // Zero interval still waits one cycle
        running <= (tmr.steps != '0);
        stepsLeft <= tmr.steps;
        tmr.done <= (tmr.steps == '0);
      end else if (running && tickCount == 32'(TICK_CYC - 1)) begin
        stepsLeft <= stepsLeft - 1'b1;
        if (stepsLeft == 1) begin
          running <= 1'b0;
          tmr.done <= 1'b1;
        end
      end
    end
  end
endmodule : tarc_interval_timer
`default_nettype wire

// ==== verilog/tarc_pkg.sv ====
// Types for the trip auto-retry controller.
// Assumes tarc_defs.svh is compiled alongside.
`include "tarc_defs.svh"
package tarc_pkg;
  typedef enum logic [1:0] {
    TARC_IDLE = 2'h0,
    TARC_WAIT = 2'h1,
    TARC_ALARM = 2'h3
  } tarc_state_t;
  typedef logic [`TARC_CAUSE_W-1:0] tarc_cause_t;
endpackage : tarc_pkg

// ==== verilog/tarc_retry_ctrl.sv ====
// Trip auto-retry controller: clears eligible trips and raises the alarm.
// Assumes protection inputs are asynchronous levels; one clock domain.
// Outputs are registered; tripReset is a one-cycle pulse.
`timescale 1ns/100ps
`default_nettype none
`include "tarc_defs.svh"
module tarc_retry_ctrl
  import tarc_pkg::*;
#(
  parameter int TICK_CYC = `TARC_TICK_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Configuration
  input wire logic [`TARC_COUNT_W-1:0] retry_count_limit,
  input wire logic [`TARC_IVL_W-1:0] retry_interval,
  // Protection side
  input wire logic [`TARC_CAUSE_W-1:0] tripCause,
  input wire logic alarmAck,
  // Drive side
  output logic tripReset,
  output logic faultAlarm,
  output logic tripped,
  output logic [`TARC_COUNT_W-1:0] retryCount
);
  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  // Pins are asynchronous: two flops before any logic reads them
  tarc_cause_t causeMeta;
  tarc_cause_t causeSync;
  tarc_cause_t causePrev;
  logic ackMeta;
  logic ackSync;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      causeMeta <= '0;
      causeSync <= '0;
      causePrev <= '0;
    end else begin
      causeMeta <= tripCause;
      causeSync <= causeMeta;
      causePrev <= causeSync;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ackMeta <= 1'b0;
      ackSync <= 1'b0;
    end else begin
      ackMeta <= alarmAck;
      ackSync <= ackMeta;
    end
  end

  // ****************************************************************
  // Cause decoding
  // ****************************************************************
  // Any cause outside the retry set, alone or mixed with others
  function automatic logic hasOther(input tarc_cause_t c);
    return ((c & ~`TARC_ELIGIBLE_MASK) != '0);
  endfunction : hasOther

  // Mixed causes are not retried: the foreign one decides
  function automatic logic isEligible(input tarc_cause_t c);
    return ((c & `TARC_ELIGIBLE_MASK) != '0) && !hasOther(c);
  endfunction : isEligible

  // A trip counts once, on the rising edge of its cause level
  tarc_cause_t newTrip;
  genvar gi;
  generate
    for (gi = 0; gi < `TARC_CAUSE_W; gi++) begin : g_edge
      assign newTrip[gi] = causeSync[gi] & ~causePrev[gi];
    end
  endgenerate

  // ****************************************************************
  // Sequencing events
  // ****************************************************************
  tarc_timer_if tmr ();
  tarc_state_t state;
  tarc_state_t next_state;
  logic retryOn;
  logic limitReached;
  logic tripSeen;
  logic tripOther;
  logic tripOver;
  logic tripRetry;
  logic otherInWait;
  logic waitDone;
  logic ackClear;

  // Limit zero switches retries off altogether
  assign retryOn = (retry_count_limit != '0);
  // Count is cumulative, so a trip past the limit alarms
  assign limitReached = (retryCount >= retry_count_limit);
  assign tripSeen = (state == TARC_IDLE) && (newTrip != '0);
  assign tripOther = tripSeen && !isEligible(causeSync);
  assign tripOver = tripSeen && !tripOther
      && (!retryOn || limitReached);
  assign tripRetry = tripSeen && !tripOther && !tripOver;
  // Further eligible edges during the wait are dropped on purpose
  assign otherInWait = (state == TARC_WAIT) && hasOther(newTrip);
  assign waitDone = (state == TARC_WAIT) && !otherInWait && tmr.done;
  assign ackClear = (state == TARC_ALARM) && ackSync
      && (causeSync == '0);

  // ****************************************************************
  // State machine
  // ****************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      TARC_IDLE: begin
        if (tripOther || tripOver) begin
          next_state = TARC_ALARM;
        end else if (tripRetry) begin
          next_state = TARC_WAIT;
        end
      end
      TARC_WAIT: begin
        if (otherInWait) begin
          next_state = TARC_ALARM;
        end else if (waitDone) begin
          next_state = TARC_IDLE;
        end
      end
      TARC_ALARM: begin
        // No automatic exit; only an operator acknowledge clears it
        if (ackClear) begin
          next_state = TARC_IDLE;
        end
      end
      default: next_state = TARC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state <= TARC_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // ****************************************************************
  // Retry counter
  // ****************************************************************
  // Cleared only by an acknowledge, never by a good restart
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      retryCount <= '0;
    end else if (ackClear) begin
      retryCount <= '0;
    end else if (tripRetry) begin
      retryCount <= retryCount + 1'b1;
    end
  end

  // ****************************************************************
  // Fault alarm and trip flag
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      faultAlarm <= 1'b0;
    end else if (tripOther || otherInWait) begin
      faultAlarm <= 1'b1;
    end else if (tripOver) begin
      faultAlarm <= 1'b1;
    end else if (ackClear) begin
      faultAlarm <= 1'b0;
    end
  end

  // Trip flag stands from the trip until its reset pulse
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tripped <= 1'b0;
    end else if (tripSeen) begin
      tripped <= 1'b1;
    end else if (waitDone || ackClear) begin
      tripped <= 1'b0;
    end
  end

  // ****************************************************************
  // Restart pulse and interval request
  // ****************************************************************
  // Alarm stays low while a retry reset is issued
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tripReset <= 1'b0;
    end else begin
      tripReset <= waitDone || ackClear;
    end
  end

  // Interval is latched at the trip; later edits wait for the next one
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      tmr.start <= 1'b0;
      tmr.steps <= '0;
    end else begin
      tmr.start <= tripRetry;
      if (tripRetry) begin
        tmr.steps <= retry_interval;
      end
    end
  end

  // ****************************************************************
  // Interval timer
  // ****************************************************************
  tarc_interval_timer #(
    .TICK_CYC(TICK_CYC)
  ) u_timer (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tmr(tmr.timer)
  );
endmodule : tarc_retry_ctrl
`default_nettype wire

// ==== verilog/tarc_timer_if.sv ====
// Interface between retry controller and its interval timer.
// Assumes a single clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "tarc_defs.svh"
interface tarc_timer_if;
  logic start;
  logic [`TARC_IVL_W-1:0] steps;
  logic done;
  modport ctrl (output start, output steps, input done);
  modport timer (input start, input steps, output done);
endinterface : tarc_timer_if
`default_nettype wire
